// >>> common/ufc_defines.vh
// constants for the usb function fifo control block
`ifndef UFC_DEFINES_VH
`define UFC_DEFINES_VH
`define UFC_IDX_W      2
`define UFC_IDX_NONE   2'h0
`define UFC_IDX_ONE    2'h1
`define UFC_IDX_TWO    2'h3
`define UFC_IDX_SECOND 2'h2
`define UFC_HS_NONE    2'h0
`define UFC_HS_ACK     2'h1
`define UFC_HS_NAK     2'h2
`define UFC_HS_STALL   2'h3
`define UFC_DATA_W     8
`define UFC_DEPTH      16
`endif

// >>> rtl/ufc_fifo.v
// parameterised valid/ready fifo with flush and empty/full tracking
`timescale 1ns/1ns
module ufc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             flush,
  input  wire [WIDTH-1:0] inData,
  input  wire             inValid,
  output wire             inReady,
  output wire [WIDTH-1:0] outData,
  output wire             outValid,
  input  wire             outReady,
  output wire [AW:0]      level
);
  // ****************************************************
  // storage and pointers
  // ****************************************************
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // data words
  reg [AW:0]      wrPtr_q;          // write pointer with wrap bit
  reg [AW:0]      rdPtr_q;          // read pointer with wrap bit
  wire            doWr;             // accepted write
  wire            doRd;             // accepted read
  assign level    = wrPtr_q - rdPtr_q;
  assign inReady  = (level != DEPTH[AW:0]);
  assign outValid = (level != {(AW+1){1'b0}});
  assign outData  = mem[rdPtr_q[AW-1:0]];
  assign doWr     = inValid & inReady & ~flush;
  assign doRd     = outValid & outReady & ~flush;
  // write side: store word
  always @(posedge clk) begin
    if (doWr) begin
      mem[wrPtr_q[AW-1:0]] <= inData;
    end
  end
  // pointer update; flush returns both to origin
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_q <= {(AW+1){1'b0}};
      rdPtr_q <= {(AW+1){1'b0}};
    end else if (flush) begin
      wrPtr_q <= {(AW+1){1'b0}};
      rdPtr_q <= {(AW+1){1'b0}};
    end else begin
      if (doWr) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (doRd) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
    end
  end
endmodule // ufc_fifo

// >>> rtl/ufc_fifo_ctrl.v
// receive/transmit endpoint fifo control with setup and iso handling
`timescale 1ns/1ns
`include "ufc_defines.vh"
module ufc_fifo_ctrl #(
  parameter DATA_W = `UFC_DATA_W,
  parameter DEPTH  = `UFC_DEPTH,
  parameter AW     = 4
) (
  input  wire              clk,
  input  wire              rst_n,
  input  wire              isoMode,
  input  wire              txStallBit,
  input  wire              rxStallBit,
  input  wire              sof,
  input  wire              setupToken,
  input  wire              inToken,
  input  wire              outToken,
  input  wire              hostAck,
  input  wire              rxEndOk,
  input  wire              txEndOk,
  input  wire [DATA_W-1:0] sieRxData,
  input  wire              sieRxValid,
  output wire              sieRxReady,
  output reg  [DATA_W-1:0] sieTxData,
  output reg               sieTxValid,
  input  wire              sieTxTake,
  input  wire              sieTxEmptyReq,
  output reg  [1:0]        handshake,
  input  wire              fwRdStrobe,
  output reg  [DATA_W-1:0] fwRdData,
  input  wire              fwReadComplete,
  input  wire              fwClrDone,
  input  wire              fwClrSetupRcvd,
  input  wire              fwClrRxUnder,
  input  wire              fwClrRxOver,
  input  wire [DATA_W-1:0] fwWrData,
  input  wire              fwWrStrobe,
  input  wire              fwTxCountWr,
  input  wire              fwClrTxOver,
  input  wire              fwClrTxUnder,
  input  wire              fwClrTxFlush,
  output reg               setupOverwriteInProgress_q,
  output reg               setupOverwriteDone_q,
  output reg               setupReceivedFlag_q,
  output reg  [1:0]        receivePacketIndex_q,
  output reg  [1:0]        transmitPacketIndex_q,
  output reg               receiveUnderrunFlag_q,
  output reg               receiveOverrunFlag_q,
  output reg               transmitOverrunFlag_q,
  output reg               transmitUnderrunFlag_q,
  output reg               transmitFlushStatus_q,
  output reg               receiveEmptyFlag_q,
  output reg               receiveFullFlag_q,
  output reg               transmitEmptyFlag_q,
  output reg               transmitFullFlag_q
);
  // ****************************************************
  // receive fifo and locking
  // ****************************************************
  wire [AW:0]       rxLevel;          // bytes held
  wire              rxOutValid;       // rx byte available
  wire [DATA_W-1:0] rxOutData;        // rx head byte
  wire              rxInReady;        // rx room
  wire              rdLocked;         // read pointer locked
  wire              receiveClearBit;  // hardware flush strobe
  wire              rxTake;           // firmware byte accepted
  wire              receive_full_flag;           // rx fifo full now
  reg               rxOverPend_q;     // iso overrun held to sof
  reg               rxPktPend_q;      // iso packet held to sof
  assign rdLocked        = setupOverwriteInProgress_q |
                           setupOverwriteDone_q;
  assign receiveClearBit = setupToken;
  assign rxTake          = fwRdStrobe & rxOutValid & ~rdLocked;
  assign receive_full_flag          = ~rxInReady;
  assign sieRxReady      = rxInReady;

  ufc_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) uRxFifo (
    .clk      (clk),
    .rst_n    (rst_n),
    .flush    (receiveClearBit),
    .inData   (sieRxData),
    .inValid  (sieRxValid),
    .inReady  (rxInReady),
    .outData  (rxOutData),
    .outValid (rxOutValid),
    .outReady (rxTake),
    .level    (rxLevel)
  );

  // ****************************************************
  // transmit fifo
  // ****************************************************
  wire [AW:0]       txLevel;    // bytes held
  wire              txOutValid; // tx byte available
  wire [DATA_W-1:0] txOutData;  // tx head byte
  wire              txInReady;  // tx room
  wire              txPop;      // send side pop
  wire              txDrop;     // hardware flush of the whole tx fifo
  reg               txUnderPend_q; // iso underrun held to sof
  reg               txSentPend_q;  // iso send held to sof
  assign txDrop = isoMode & sof &
                  (transmitPacketIndex_q == `UFC_IDX_TWO);
  assign txPop  = sieTxTake & txOutValid;

  ufc_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) uTxFifo (
    .clk      (clk),
    .rst_n    (rst_n),
    .flush    (txDrop),
    .inData   (fwWrData),
    .inValid  (fwWrStrobe),
    .inReady  (txInReady),
    .outData  (txOutData),
    .outValid (txOutValid),
    .outReady (txPop),
    .level    (txLevel)
  );
  // tx level kept beside the flags for a later byte-count readback

  // ****************************************************
  // setup overwrite flags
  // ****************************************************
  // in-progress on setup, done after ack; set beats clear
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      setupOverwriteInProgress_q <= 1'b0;
      setupOverwriteDone_q       <= 1'b0;
      setupReceivedFlag_q        <= 1'b0;
    end else begin
      if (setupToken) begin
        setupOverwriteInProgress_q <= 1'b1;
        setupReceivedFlag_q        <= 1'b1;
      end else if (setupOverwriteInProgress_q & hostAck) begin
        setupOverwriteInProgress_q <= 1'b0;
      end
      if (setupOverwriteInProgress_q & hostAck & ~setupToken) begin
        setupOverwriteDone_q <= 1'b1;
      end else if (fwClrDone | setupToken) begin
        setupOverwriteDone_q <= 1'b0;
      end
      if (fwClrSetupRcvd & ~setupToken) begin
        setupReceivedFlag_q <= 1'b0;
      end
    end
  end

  // ****************************************************
  // handshake to serial line engine
  // ****************************************************
  // setup always acked; setup-received naks in/out over stall
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      handshake <= `UFC_HS_NONE;
    end else if (setupToken) begin
      handshake <= `UFC_HS_ACK;
    end else if ((inToken | outToken) & setupReceivedFlag_q) begin
      handshake <= `UFC_HS_NAK;
    end else if ((inToken & txStallBit) | (outToken & rxStallBit)) begin
      handshake <= `UFC_HS_STALL;
    end else if (outToken & receive_full_flag) begin
      handshake <= `UFC_HS_NAK;
    end else if (inToken | outToken) begin
      handshake <= `UFC_HS_ACK;
    end else begin
      handshake <= `UFC_HS_NONE;
    end
  end

  // ****************************************************
  // receive flags and packet index
  // ****************************************************
  wire rdComplete; // accepted read-complete
  wire rxOverNow;  // sie write into full fifo
  assign rdComplete = fwReadComplete & ~rdLocked;
  assign rxOverNow  = sieRxValid & receive_full_flag;
  // index, underrun, overrun; iso defers usb side to sof
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      receivePacketIndex_q  <= `UFC_IDX_NONE;
      receiveUnderrunFlag_q <= 1'b0;
      receiveOverrunFlag_q  <= 1'b0;
      rxOverPend_q          <= 1'b0;
      rxPktPend_q           <= 1'b0;
      fwRdData              <= {DATA_W{1'b0}};
    end else begin
      if (rxTake) begin
        fwRdData <= rxOutData;
      end
      if (fwRdStrobe & ~rxOutValid & ~rdLocked) begin
        receiveUnderrunFlag_q <= 1'b1;
      end else if (fwClrRxUnder) begin
        receiveUnderrunFlag_q <= 1'b0;
      end
      if (isoMode) begin
        rxOverPend_q <= sof ? 1'b0 : (rxOverPend_q | rxOverNow);
        rxPktPend_q  <= sof ? 1'b0 : (rxPktPend_q | rxEndOk);
      end
      if (isoMode ? (sof & (rxOverPend_q | rxOverNow)) : rxOverNow) begin
        receiveOverrunFlag_q <= 1'b1;
      end else if (fwClrRxOver) begin
        receiveOverrunFlag_q <= 1'b0;
      end
      if (receiveClearBit) begin
        receivePacketIndex_q <= `UFC_IDX_NONE;
      end else if (isoMode) begin
        receivePacketIndex_q <= rxIdx(rxIdx(receivePacketIndex_q,
                                  1'b0, rdComplete),
                                  sof & (rxPktPend_q | rxEndOk), 1'b0);
      end else begin
        receivePacketIndex_q <= rxIdx(receivePacketIndex_q,
                                      rxEndOk, rdComplete);
      end
    end
  end

  // next index for one add and/or one remove
  function [1:0] rxIdx;
    input [1:0] cur;
    input       add;
    input       rem;
    begin
      case ({add, rem})
        2'h2: rxIdx = (cur == `UFC_IDX_NONE) ? `UFC_IDX_ONE :
                      `UFC_IDX_TWO;
        2'h1: rxIdx = (cur == `UFC_IDX_TWO) ? `UFC_IDX_SECOND :
                      `UFC_IDX_NONE;
        default: rxIdx = cur;
      endcase
    end
  endfunction

  // ****************************************************
  // transmit flags, rx and tx empty/full flags, and transmit packet index
  // ****************************************************
  // live empty/full, immediate overrun, underrun at sof in iso, immediate otherwise
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      transmitPacketIndex_q  <= `UFC_IDX_NONE;
      transmitOverrunFlag_q  <= 1'b0;
      transmitUnderrunFlag_q <= 1'b0;
      transmitFlushStatus_q  <= 1'b0;
      txUnderPend_q          <= 1'b0;
      txSentPend_q           <= 1'b0;
      receiveEmptyFlag_q     <= 1'b1;
      receiveFullFlag_q      <= 1'b0;
      transmitEmptyFlag_q    <= 1'b1;
      transmitFullFlag_q     <= 1'b0;
      sieTxData              <= {DATA_W{1'b0}};
      sieTxValid             <= 1'b0;
    end else begin
      receiveEmptyFlag_q  <= ~rxOutValid;
      receiveFullFlag_q   <= receive_full_flag;
      transmitEmptyFlag_q <= ~txOutValid;
      transmitFullFlag_q  <= ~txInReady;
      // iso send only once a whole packet is indexed
      sieTxValid <= txOutValid & (~isoMode |
                    (transmitPacketIndex_q != `UFC_IDX_NONE));
      sieTxData  <= txOutData;
      if (fwWrStrobe & ~txInReady) begin
        transmitOverrunFlag_q <= 1'b1;
      end else if (fwClrTxOver) begin
        transmitOverrunFlag_q <= 1'b0;
      end
      if (isoMode) begin
        txUnderPend_q <= sof ? 1'b0 : (txUnderPend_q | sieTxEmptyReq);
        txSentPend_q  <= sof ? 1'b0 : (txSentPend_q | txEndOk);
      end
      if (isoMode ? (sof & (txUnderPend_q | sieTxEmptyReq)) :
          sieTxEmptyReq) begin
        transmitUnderrunFlag_q <= 1'b1;
      end else if (fwClrTxUnder) begin
        transmitUnderrunFlag_q <= 1'b0;
      end
      if (txDrop) begin
        transmitFlushStatus_q <= 1'b1;
        transmitPacketIndex_q <= `UFC_IDX_ONE;
      end else begin
        if (fwClrTxFlush) begin
          transmitFlushStatus_q <= 1'b0;
        end
        if (isoMode) begin
          transmitPacketIndex_q <= rxIdx(rxIdx(transmitPacketIndex_q,
                                   fwTxCountWr, 1'b0),
                                   1'b0, sof & (txSentPend_q | txEndOk));
        end else begin
          transmitPacketIndex_q <= rxIdx(transmitPacketIndex_q,
                                         fwTxCountWr, txEndOk);
        end
      end
    end
  end
  // no completion interrupt output exists; sof paces iso
endmodule // ufc_fifo_ctrl

// >>> verif/ufc_fifo_ctrl_assertions.sv
// assertion checker for the fifo control block
`timescale 1ns/1ns
`include "ufc_defines.vh"
module ufc_checker (
  input wire       clk,
  input wire       rst_n,
  input wire       isoMode,
  input wire       sof,
  input wire       setupToken,
  input wire       hostAck,
  input wire       fwTxCountWr,
  input wire [1:0] handshake,
  input wire       setupOverwriteInProgress_q,
  input wire       setupOverwriteDone_q,
  input wire [1:0] transmitPacketIndex_q,
  input wire       transmitUnderrunFlag_q,
  input wire       transmitFlushStatus_q,
  input wire       receiveOverrunFlag_q
);
  // ************************************
  // setup sequence and frame timing
  // ************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_setup_ack: assert property (
    setupToken |=> handshake == `UFC_HS_ACK) else $error("setup not acked");
  a_setup_start: assert property (
    setupToken |=> setupOverwriteInProgress_q && !setupOverwriteDone_q)
    else $error("setup flags wrong");
  a_setup_done: assert property (
    hostAck && setupOverwriteInProgress_q && !setupToken
    |=> !setupOverwriteInProgress_q && setupOverwriteDone_q)
    else $error("setup not completed");
  a_tx_index_up: assert property (
    isoMode && fwTxCountWr && !sof && transmitPacketIndex_q == `UFC_IDX_NONE
    |=> transmitPacketIndex_q == `UFC_IDX_ONE) else $error("index not up");
  a_tx_index_hold: assert property (
    isoMode && !sof && !fwTxCountWr |=> $stable(transmitPacketIndex_q))
    else $error("tx index moved inside frame");
  a_tx_under_sof: assert property (
    isoMode && !sof && !transmitUnderrunFlag_q |=> !transmitUnderrunFlag_q)
    else $error("tx underrun inside frame");
  a_rx_over_sof: assert property (
    isoMode && !sof && !receiveOverrunFlag_q |=> !receiveOverrunFlag_q)
    else $error("rx overrun inside frame");
  a_tx_drop: assert property (
    isoMode && sof && !fwTxCountWr && transmitPacketIndex_q == `UFC_IDX_TWO
    |=> transmitFlushStatus_q && transmitPacketIndex_q == `UFC_IDX_ONE)
    else $error("oldest packet not dropped");
endmodule // ufc_checker
bind ufc_fifo_ctrl ufc_checker chk_u (.*);

// >>> verif/ufc_host_model.sv
// serial engine side model: feeds receive bytes, drains transmit bytes
`timescale 1ns/1ns
module ufc_host_model (
  input  wire        clk,
  input  wire        slow,
  input  wire        drain,
  output logic [7:0] sieRxData = 8'h00,
  output logic       sieRxValid = 1'b0,
  input  wire        sieRxReady,
  output logic       rxEndOk = 1'b0,
  input  wire  [7:0] sieTxData,
  input  wire        sieTxValid,
  output logic       sieTxTake = 1'b0,
  output logic [7:0] gotData = 8'h00,
  output logic       gotValid = 1'b0
);
  logic [1:0] gap_q = 2'h0;  // pacing of transmit pops
  // send n bytes counting up from base, then mark a good packet
  task automatic send(input logic [7:0] base, input int n, output logic ok);
    int k;
    ok = 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      sieRxData  <= base + i[7:0];
      sieRxValid <= 1'b1;
      k = 0;
      do begin
        @(posedge clk);
        k++;
      end while (!sieRxReady && k < 40);
      if (!sieRxReady) ok = 1'b0;
      sieRxValid <= 1'b0;
      sieRxData  <= ~(base + i[7:0]);  // released line shows inverse
      if (slow) @(posedge clk);
    end
    @(posedge clk);
    rxEndOk <= 1'b1;
    @(posedge clk);
    rxEndOk <= 1'b0;
    #1;
  endtask
  // pop one byte in four cycles, so the far side stalls the drain
  always @(posedge clk) begin
    gap_q     <= gap_q + 2'h1;
    gotValid  <= sieTxTake;
    gotData   <= sieTxData;
    sieTxTake <= drain && sieTxValid && gap_q == 2'h3;
  end
endmodule // ufc_host_model

// >>> verif/usb_function_fifo_setup_iso_control_bench.sv
// self-checking bench for the usb function fifo control block
`timescale 1ns/1ns
`include "ufc_defines.vh"
module usb_function_fifo_setup_iso_control_bench;
  logic clk = 0, rst_n = 0, isoMode = 0, txStallBit = 0, rxStallBit = 0;
  logic slow = 0, drain = 0, fwRdStrobe = 0, fwWrStrobe = 0, rdP = 0, ok;
  logic [15:0] pls = '0;  // strobe inputs, one bit each
  logic [7:0] fwWrData = '0, base, sieRxData, sieTxData, fwRdData, gotData;
  logic [1:0] handshake, receivePacketIndex_q, transmitPacketIndex_q;
  logic sieRxValid, sieRxReady, sieTxValid, sieTxTake, rxEndOk, gotValid;
  logic setupOverwriteInProgress_q, setupOverwriteDone_q, setupReceivedFlag_q;
  logic receiveUnderrunFlag_q, receiveOverrunFlag_q, transmitOverrunFlag_q;
  logic transmitUnderrunFlag_q, transmitFlushStatus_q, receiveEmptyFlag_q;
  logic receiveFullFlag_q, transmitEmptyFlag_q, transmitFullFlag_q;
  logic [7:0] rdQ[$], txQ[$];  // expected read and sent bytes
  logic [1:0] hsQ[$];          // expected handshakes
  int failures = 0, nCompared = 0, k;
  always #5 clk = ~clk;
  ufc_fifo_ctrl dut_u (.*, .setupToken(pls[0]), .inToken(pls[1]),
    .outToken(pls[2]), .hostAck(pls[3]), .sof(pls[4]),
    .fwReadComplete(pls[5]), .fwClrDone(pls[6]), .fwClrSetupRcvd(pls[7]),
    .fwTxCountWr(pls[8]), .txEndOk(pls[9]), .sieTxEmptyReq(pls[10]),
    .fwClrRxUnder(pls[11]), .fwClrRxOver(pls[12]), .fwClrTxOver(pls[13]),
    .fwClrTxUnder(pls[14]), .fwClrTxFlush(pls[15]));
  ufc_host_model hostU (.*);
  // ************************************
  // shared tasks
  // ************************************
  task end_sim;
    $display("compared %0d, mismatches %0d", nCompared, failures);
    if (failures == 0 && nCompared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    nCompared++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // one-cycle strobe; one more edge so registered flags settle
  task automatic pulse(input int b);
    @(posedge clk);
    pls[b] <= 1'b1;
    @(posedge clk);
    pls[b] <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  // back-to-back reads, noting expected bytes when asked
  task automatic rd(input int n, input logic [7:0] b, input logic exp);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      fwRdStrobe <= 1'b1;
      if (exp) rdQ.push_back(b + i[7:0]);
    end
    @(posedge clk);
    fwRdStrobe <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  // back-to-back random writes, noting them when they will be sent
  task automatic wr(input int n, input logic keep);
    logic [7:0] d;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      d = 8'($urandom);
      fwWrData   <= d;
      fwWrStrobe <= 1'b1;
      if (keep) txQ.push_back(d);
    end
    @(posedge clk);
    fwWrStrobe <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  // result watcher: oldest note against each result shown
  always @(posedge clk) begin
    rdP <= fwRdStrobe;
    if (rdP && rdQ.size() > 0) chk(fwRdData, rdQ.pop_front());
    if (rst_n && handshake !== `UFC_HS_NONE)
      chk(handshake, hsQ.pop_front());
    if (gotValid) chk(gotData, txQ.pop_front());
  end
  // ************************************
  // scenarios
  // ************************************
  initial begin
    void'($urandom(48));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    pulse(12);
    chk(receiveEmptyFlag_q, 1'b1);
    chk(transmitEmptyFlag_q, 1'b1);
    $display("reset test done");
    // setup over a stale unread packet, stalls set
    base = 8'($urandom);
    hostU.send(base, 3, ok);
    hsQ.push_back(`UFC_HS_ACK);
    pulse(0);
    chk(receiveEmptyFlag_q, 1'b1);
    base = 8'($urandom);
    hostU.send(base, 8, ok);
    pulse(5);
    chk(receivePacketIndex_q, `UFC_IDX_ONE);
    @(posedge clk);
    txStallBit <= 1'b1;
    rxStallBit <= 1'b1;
    hsQ.push_back(`UFC_HS_NAK);
    pulse(1);
    hsQ.push_back(`UFC_HS_NAK);
    pulse(2);
    pulse(3);
    chk(setupOverwriteDone_q, 1'b1);
    rd(1, 0, 0);
    chk(receiveUnderrunFlag_q, 1'b0);
    pulse(7);
    pulse(6);
    rd(8, base, 1);
    chk(receiveEmptyFlag_q, 1'b1);
    rd(1, 0, 0);
    chk(receiveUnderrunFlag_q, 1'b1);
    pulse(5);
    chk(receivePacketIndex_q, `UFC_IDX_NONE);
    hsQ.push_back(`UFC_HS_ACK);
    pulse(0);
    pulse(3);
    chk(setupOverwriteDone_q, 1'b1);
    chk(receiveUnderrunFlag_q, 1'b1);
    pulse(6);
    pulse(7);
    pulse(11);
    @(posedge clk);
    txStallBit <= 1'b0;
    rxStallBit <= 1'b0;
    slow       <= 1'b1;
    $display("setup test done");
    // fill receive side until it refuses, then drain it
    base = 8'($urandom);
    hostU.send(base, 16, ok);
    chk(ok, 1'b1);
    chk(receiveFullFlag_q, 1'b1);
    chk(sieRxReady, 1'b0);
    rd(16, base, 1);
    chk(receiveEmptyFlag_q, 1'b1);
    pulse(5);
    chk(receivePacketIndex_q, `UFC_IDX_NONE);
    @(posedge clk);
    isoMode <= 1'b1;
    $display("fill test done");
    // iso transmit: overrun, deferred index and underrun, drop
    wr(16, 1);
    chk(transmitFullFlag_q, 1'b1);
    wr(1, 0);
    chk(transmitOverrunFlag_q, 1'b1);
    pulse(8);
    chk(transmitPacketIndex_q, `UFC_IDX_ONE);
    drain <= 1'b1;
    for (k = 0; k < 200 && transmitEmptyFlag_q !== 1'b1; k++) @(posedge clk);
    drain <= 1'b0;
    if (k == 200) begin
      failures++;
      end_sim;
    end
    pulse(9);
    pulse(10);
    chk(transmitUnderrunFlag_q, 1'b0);
    chk(transmitPacketIndex_q, `UFC_IDX_ONE);
    pulse(4);
    chk(transmitUnderrunFlag_q, 1'b1);
    chk(transmitPacketIndex_q, `UFC_IDX_NONE);
    wr(2, 0);
    pulse(8);
    wr(2, 0);
    pulse(8);
    chk(transmitPacketIndex_q, `UFC_IDX_TWO);
    pulse(4);
    chk(transmitFlushStatus_q, 1'b1);
    chk(transmitPacketIndex_q, `UFC_IDX_ONE);
    pulse(15);
    chk(transmitFlushStatus_q, 1'b0);
    $display("iso transmit test done");
    // iso receive: index at frame start, read-complete at once
    base = 8'($urandom);
    hostU.send(base, 4, ok);
    chk(receivePacketIndex_q, `UFC_IDX_NONE);
    chk(receiveEmptyFlag_q, 1'b0);
    pulse(4);
    chk(receivePacketIndex_q, `UFC_IDX_ONE);
    rd(4, base, 1);
    pulse(5);
    chk(receivePacketIndex_q, `UFC_IDX_NONE);
    rd(1, 0, 0);
    chk(receiveUnderrunFlag_q, 1'b1);
    $display("iso receive test done");
    end_sim;
  end
endmodule // usb_function_fifo_setup_iso_control_bench
